/* File: cch_pkg.sv */
// package for the common command handler
// assumes an apb master and a command decoder feeding parsed command codes
package cch_pkg;

  // --------------------------------------------------------------
  // register map (byte addresses)
  // --------------------------------------------------------------
  localparam logic [7:0] ADDR_CMD = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_SESR = 8'h08;
  localparam logic [7:0] ADDR_INT_STAT = 8'h0c;
  localparam logic [7:0] ADDR_INT_MASK = 8'h10;
  localparam logic [7:0] ADDR_RESP = 8'h14;
  localparam logic [7:0] ADDR_SETTINGS = 8'h18;
  localparam logic [7:0] ADDR_SELFTEST = 8'h1c;
  localparam logic [7:0] ADDR_IDENT = 8'h20;

  // --------------------------------------------------------------
  // command register fields
  // --------------------------------------------------------------
  localparam int CMD_CODE_LSB = 0;
  localparam int CMD_PARAM_BIT = 4;
  localparam int CMD_LEN_LSB = 16;
  localparam logic [15:0] RESP_MAX_BYTES = 16'h012c;

  // event status bits
  localparam int SESR_CME = 5;
  localparam int SESR_EXE = 4;
  localparam int SESR_QYE = 2;

  // interrupt status bits
  localparam int IRQ_CME = 0;
  localparam int IRQ_EXE = 1;
  localparam int IRQ_QYE = 2;
  localparam int IRQ_DONE = 3;

  // self-test result bits
  localparam logic [7:0] TST_USED_MASK = 8'h0f;

  // --------------------------------------------------------------
  // timing
  // --------------------------------------------------------------
  localparam int CLK_HZ = 50_000_000;
  localparam int DELAY_MIN_MS = 20;
  localparam int DELAY_MAX_MS = 500;
  localparam int DELAY_MIN_CYC = CLK_HZ / 1000 * DELAY_MIN_MS;
  localparam int DELAY_MAX_CYC = CLK_HZ / 1000 * DELAY_MAX_MS;

  // --------------------------------------------------------------
  // defaults after device reset
  // --------------------------------------------------------------
  localparam logic [3:0] PARAM_Z_PHASE = 4'h1;
  localparam logic [15:0] FREQ_1KHZ = 16'h03e8;
  localparam logic [7:0] LEVEL_1V = 8'h0a;
  localparam logic [1:0] SPEED_NORMAL = 2'h1;
  localparam logic [1:0] CMP_BOTH = 2'h3;

  typedef enum logic [3:0] {
    CMD_NONE = 4'h0,
    CMD_IDN = 4'h1,
    CMD_RST = 4'h2,
    CMD_TRG = 4'h3,
    CMD_TST = 4'h4,
    CMD_WAI = 4'h5,
    CMD_MEAS = 4'h6,
    CMD_SPEC = 4'h7
  } cch_cmd_t;

  typedef struct packed {
    logic [3:0] param_sel;
    logic [15:0] freq;
    logic [7:0] level;
    logic range_auto;
    logic circuit_auto;
    logic open_comp;
    logic short_comp;
    logic trig_ext;
    logic [1:0] speed;
    logic beep_key;
    logic beep_cmp;
    logic [1:0] cmp_target;
    logic cmp_upper_on;
    logic cmp_lower_on;
  } cch_settings_t;

  typedef struct packed {
    logic meas_start;
    logic selftest_start;
    logic panel_clear;
  } cch_engine_req_t;

  typedef enum {
    ST_IDLE,
    ST_DELAY,
    ST_EXEC,
    ST_TEST,
    ST_WAIT
  } cch_state_t;

endpackage : cch_pkg

/* File: cch_delay.sv */
// processing delay counter between command receipt and analysis
// assumes start pulses only while idle
`timescale 1ns/1ps
module cch_delay #(
  parameter int MIN_CYC = cch_pkg::DELAY_MIN_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic start,
  output logic done
);

  typedef struct packed {
    logic busy;
    logic [31:0] cnt;
    logic done;
  } cch_dly_state_t;

  cch_dly_state_t st_ff;
  cch_dly_state_t nxt_st;

  always_comb begin
    nxt_st = st_ff;
    nxt_st.done = 1'b0;
    if (start) begin
      nxt_st.busy = 1'b1;
      nxt_st.cnt = 32'h0;
    end else if (st_ff.busy) begin
      if (st_ff.cnt >= 32'(MIN_CYC - 1)) begin
        nxt_st.busy = 1'b0;
        nxt_st.done = 1'b1;
      end else begin
        nxt_st.cnt = st_ff.cnt + 32'h1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign done = st_ff.done;

endmodule : cch_delay

/* File: cch_handler.sv */
// common command handler: executes parsed common commands over apb
// assumes a text parser writes one command at a time to the command register
//
// Implementation choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps

// Notes on behaviour
// - identification answer is maker, model, option, version, no header
// - response longer than 300 bytes raises query error instead
// - reset restores impedance/phase, 1 kHz, 1 V, auto range, auto circuit
// - reset turns compensation off, internal trigger, normal speed, key beep on
// - reset sets comparator to both parameters, limits off, clears panels
// - reset, trigger, wait with a data parameter raise command error
// - external trigger mode: each trigger starts exactly one measurement
// - trigger in internal mode raises execution error, no measurement
// - trigger or self-test during compensation raises execution error
// - self-test bits: rom, ram, io, interrupt; bits 4 to 7 zero
// - self-test runs checks then returns the code without header
// - wait stalls later commands until running operation completes
// - only measurement query overlaps; all others finish before the next
// - command, execution, query errors latch event bits 5, 4, 2
// - receipt to analysis takes between 20 ms and 500 ms; the code waits a fixed DELAY_CYC cycles, 20 ms by default
module cch_handler #(
  parameter int DELAY_CYC = cch_pkg::DELAY_MIN_CYC,
  parameter logic [31:0] IDENT_WORD = 32'h0001_0001 // arbitrary value
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic meas_busy,
  input wire logic comp_active,
  input wire logic selftest_done,
  input wire logic [7:0] selftest_code,
  output cch_pkg::cch_settings_t settings,
  output cch_pkg::cch_engine_req_t engine_req,
  output logic irq
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    cch_pkg::cch_state_t fsm;
    cch_pkg::cch_cmd_t cmd;
    logic cmd_param;
    logic [15:0] cmd_len;
    cch_pkg::cch_settings_t set;
    cch_pkg::cch_engine_req_t req;
    logic [7:0] sesr;
    logic [3:0] int_stat;
    logic [3:0] int_mask;
    logic [31:0] resp;
    logic resp_valid;
    logic [7:0] test_code;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
  } cch_state_s_t;

  cch_state_s_t st_ff;
  cch_state_s_t nxt_st;
  logic dly_start;
  logic dly_done;
  // settings width, wider than one bus word
  localparam int SET_W = $bits(cch_pkg::cch_settings_t);

  function automatic cch_pkg::cch_settings_t reset_defaults();
    cch_pkg::cch_settings_t s;
    s = '0;
    s.param_sel = cch_pkg::PARAM_Z_PHASE;
    s.freq = cch_pkg::FREQ_1KHZ;
    s.level = cch_pkg::LEVEL_1V;
    s.range_auto = 1'b1;
    s.circuit_auto = 1'b1;
    s.open_comp = 1'b0;
    s.short_comp = 1'b0;
    s.trig_ext = 1'b0;
    s.speed = cch_pkg::SPEED_NORMAL;
    s.beep_key = 1'b1;
    s.beep_cmp = 1'b0;
    s.cmp_target = cch_pkg::CMP_BOTH;
    s.cmp_upper_on = 1'b0;
    s.cmp_lower_on = 1'b0;
    return s;
  endfunction : reset_defaults

  function automatic logic is_addr(input logic [7:0] a, input logic [7:0] ref_a);
    return a == ref_a;
  endfunction : is_addr

  // every address that answers without a slave error
  function automatic logic is_mapped(input logic [7:0] a);
    logic hit;
    hit = is_addr(a, cch_pkg::ADDR_CMD) || is_addr(a, cch_pkg::ADDR_STATUS) ||
          is_addr(a, cch_pkg::ADDR_SESR) || is_addr(a, cch_pkg::ADDR_INT_STAT) ||
          is_addr(a, cch_pkg::ADDR_INT_MASK) || is_addr(a, cch_pkg::ADDR_RESP) ||
          is_addr(a, cch_pkg::ADDR_SETTINGS) || is_addr(a, cch_pkg::ADDR_SELFTEST) ||
          is_addr(a, cch_pkg::ADDR_IDENT);
    return hit;
  endfunction : is_mapped

  // ----------------------------------------------------------------
  // processing delay
  // ----------------------------------------------------------------
  cch_delay #(
    .MIN_CYC(DELAY_CYC)
  ) u_delay (
    .pclk(pclk),
    .presetn(presetn),
    .start(dly_start),
    .done(dly_done)
  );

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic wr_acc;
    logic rd_acc;
    logic [7:0] ev;
    wr_acc = psel && penable && pwrite && st_ff.pready;
    rd_acc = psel && penable && !pwrite && st_ff.pready;
    ev = 8'h00;
    nxt_st = st_ff;
    nxt_st.req = '0;
    nxt_st.pready = psel && !penable;
    nxt_st.pslverr = 1'b0;
    dly_start = 1'b0;

    // command sequencer
    unique case (st_ff.fsm)
      cch_pkg::ST_IDLE: begin
      end
      cch_pkg::ST_DELAY: begin
        if (dly_done) begin
          nxt_st.fsm = cch_pkg::ST_EXEC;
        end
      end
      cch_pkg::ST_EXEC: begin
        nxt_st.fsm = cch_pkg::ST_IDLE;
        if (st_ff.cmd_param && (st_ff.cmd == cch_pkg::CMD_RST ||
            st_ff.cmd == cch_pkg::CMD_TRG || st_ff.cmd == cch_pkg::CMD_WAI)) begin
          ev[cch_pkg::SESR_CME] = 1'b1;
        end else begin
          unique case (st_ff.cmd)
            cch_pkg::CMD_IDN: begin
              if (st_ff.cmd_len > cch_pkg::RESP_MAX_BYTES) begin
                ev[cch_pkg::SESR_QYE] = 1'b1;
              end else begin
                nxt_st.resp = IDENT_WORD;
                nxt_st.resp_valid = 1'b1;
              end
            end
            cch_pkg::CMD_RST: begin
              nxt_st.set = reset_defaults();
              nxt_st.req.panel_clear = 1'b1;
            end
            cch_pkg::CMD_TRG: begin
              if (comp_active) begin
                ev[cch_pkg::SESR_EXE] = 1'b1;
              end else if (!st_ff.set.trig_ext) begin
                ev[cch_pkg::SESR_EXE] = 1'b1;
              end else begin
                nxt_st.req.meas_start = 1'b1;
              end
            end
            cch_pkg::CMD_TST: begin
              if (comp_active) begin
                ev[cch_pkg::SESR_EXE] = 1'b1;
              end else begin
                nxt_st.req.selftest_start = 1'b1;
                nxt_st.fsm = cch_pkg::ST_TEST;
              end
            end
            cch_pkg::CMD_WAI: begin
              nxt_st.fsm = cch_pkg::ST_WAIT;
            end
            default: begin
            end
          endcase
        end
      end
      cch_pkg::ST_TEST: begin
        if (selftest_done) begin
          nxt_st.fsm = cch_pkg::ST_IDLE;
          if (st_ff.cmd_len > cch_pkg::RESP_MAX_BYTES) begin
            ev[cch_pkg::SESR_QYE] = 1'b1;
          end else begin
            nxt_st.test_code = selftest_code & cch_pkg::TST_USED_MASK;
            nxt_st.resp = {24'h0, selftest_code & cch_pkg::TST_USED_MASK};
            nxt_st.resp_valid = 1'b1;
          end
        end
      end
      cch_pkg::ST_WAIT: begin
        if (!meas_busy) begin
          nxt_st.fsm = cch_pkg::ST_IDLE;
        end
      end
    endcase

    // slave error decided in the setup cycle, so it stands with pready
    // a refused command write is then ignored at the access edge
    if (psel && !penable) begin
      if (!is_mapped(paddr)) begin
        nxt_st.pslverr = 1'b1;
      end else if (pwrite && is_addr(paddr, cch_pkg::ADDR_CMD) &&
                   st_ff.fsm != cch_pkg::ST_IDLE) begin
        nxt_st.pslverr = 1'b1;
      end
    end

    // register writes
    if (wr_acc) begin
      if (is_addr(paddr, cch_pkg::ADDR_CMD)) begin
        // new command accepted only when idle, in order
        if (!st_ff.pslverr) begin
          nxt_st.cmd = cch_pkg::cch_cmd_t'(pwdata[cch_pkg::CMD_CODE_LSB +: 4]);
          nxt_st.cmd_param = pwdata[cch_pkg::CMD_PARAM_BIT];
          nxt_st.cmd_len = pwdata[cch_pkg::CMD_LEN_LSB +: 16];
          nxt_st.resp_valid = 1'b0;
          nxt_st.fsm = cch_pkg::ST_DELAY;
          dly_start = 1'b1;
        end
      end else if (is_addr(paddr, cch_pkg::ADDR_SESR)) begin
        nxt_st.sesr = st_ff.sesr & ~pwdata[7:0];
      end else if (is_addr(paddr, cch_pkg::ADDR_INT_STAT)) begin
        nxt_st.int_stat = st_ff.int_stat & ~pwdata[3:0];
      end else if (is_addr(paddr, cch_pkg::ADDR_INT_MASK)) begin
        nxt_st.int_mask = pwdata[3:0];
      end else if (is_addr(paddr, cch_pkg::ADDR_SETTINGS)) begin
        // only the low word is on the bus; upper bits keep their value
        nxt_st.set = cch_pkg::cch_settings_t'({st_ff.set[SET_W-1:32], pwdata});
      end
    end

    // register reads
    nxt_st.prdata = 32'h0;
    if (psel && !penable && !pwrite) begin
      if (is_addr(paddr, cch_pkg::ADDR_CMD)) begin
        nxt_st.prdata = {16'h0, 11'h0, st_ff.cmd_param, st_ff.cmd};
      end else if (is_addr(paddr, cch_pkg::ADDR_STATUS)) begin
        nxt_st.prdata = {28'h0, st_ff.resp_valid, meas_busy, comp_active,
                         st_ff.fsm != cch_pkg::ST_IDLE};
      end else if (is_addr(paddr, cch_pkg::ADDR_SESR)) begin
        nxt_st.prdata = {24'h0, st_ff.sesr};
      end else if (is_addr(paddr, cch_pkg::ADDR_INT_STAT)) begin
        nxt_st.prdata = {28'h0, st_ff.int_stat};
      end else if (is_addr(paddr, cch_pkg::ADDR_INT_MASK)) begin
        nxt_st.prdata = {28'h0, st_ff.int_mask};
      end else if (is_addr(paddr, cch_pkg::ADDR_RESP)) begin
        nxt_st.prdata = st_ff.resp;
      end else if (is_addr(paddr, cch_pkg::ADDR_SETTINGS)) begin
        nxt_st.prdata = 32'(st_ff.set);
      end else if (is_addr(paddr, cch_pkg::ADDR_SELFTEST)) begin
        nxt_st.prdata = {24'h0, st_ff.test_code};
      end else if (is_addr(paddr, cch_pkg::ADDR_IDENT)) begin
        nxt_st.prdata = IDENT_WORD;
      end else begin
        nxt_st.pslverr = 1'b1;
      end
    end
    if (rd_acc) begin
      nxt_st.prdata = st_ff.prdata;
    end
    // events: set wins over clear
    nxt_st.sesr = nxt_st.sesr | ev;
    nxt_st.int_stat = nxt_st.int_stat | {
      nxt_st.resp_valid && !st_ff.resp_valid,
      ev[cch_pkg::SESR_QYE], ev[cch_pkg::SESR_EXE], ev[cch_pkg::SESR_CME]};
    nxt_st.irq = |(nxt_st.int_stat & nxt_st.int_mask);
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= '0;
      st_ff.fsm <= cch_pkg::ST_IDLE;
      st_ff.set <= reset_defaults();
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign prdata = st_ff.prdata;
  assign pready = st_ff.pready;
  assign pslverr = st_ff.pslverr;
  assign settings = st_ff.set;
  assign engine_req = st_ff.req;
  assign irq = st_ff.irq;

endmodule : cch_handler

/* File: cch_handler_assertions.sv */
// checker for the common command handler ports
// assumes binding onto cch_handler from the testbench top file
`timescale 1ns/1ps
module cch_handler_assertions (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic comp_active,
  input wire cch_pkg::cch_settings_t settings,
  input wire cch_pkg::cch_engine_req_t engine_req
);
  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  setup_ready_a: assert property (psel && !penable |=> pready) else $error("no ready");
  ready_single_a: assert property (pready |=> !pready) else $error("ready too long");
  ready_access_a: assert property (pready |-> psel && penable) else $error("stray ready");
  err_ready_a: assert property (pslverr |-> pready) else $error("stray error");
  unmapped_zero_a: assert property (psel && penable && pready && !pwrite && paddr > 8'h20
    |-> prdata == 32'h0 && pslverr) else $error("unmapped read");
  meas_pulse_a: assert property (engine_req.meas_start |=> !engine_req.meas_start)
    else $error("measurement_result_query start too long");
  meas_ext_a: assert property (engine_req.meas_start |-> settings.trig_ext)
    else $error("measurement_result_query in internal mode");
  meas_comp_a: assert property (engine_req.meas_start |-> !$past(comp_active))
    else $error("measurement_result_query during compensation");
  test_comp_a: assert property (engine_req.selftest_start |-> !$past(comp_active))
    else $error("self test during compensation");
  clear_dflt_a: assert property (engine_req.panel_clear |-> ##[0:2]
    settings.freq == cch_pkg::FREQ_1KHZ && !settings.trig_ext) else $error("no defaults");
endmodule : cch_handler_assertions

/* File: cch_engine_model.sv */
// measurement engine model on the far side of the handler
// assumes one-cycle request pulses from the handler
`timescale 1ns/1ps
module cch_engine_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire cch_pkg::cch_engine_req_t engine_req,
  input wire logic comp_on,
  input wire logic [7:0] tcode,
  output logic meas_busy,
  output logic comp_active,
  output logic selftest_done,
  output logic [7:0] selftest_code
);
  // ------------------------------------------------------------
  // busy and self test timers
  // ------------------------------------------------------------
  int mcnt_ff;
  int tcnt_ff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mcnt_ff <= 0;
      tcnt_ff <= 0;
    end else begin
      if (engine_req.meas_start) mcnt_ff <= 60;
      else if (mcnt_ff > 0) mcnt_ff <= mcnt_ff - 1;
      if (engine_req.selftest_start) tcnt_ff <= 6;
      else if (tcnt_ff > 0) tcnt_ff <= tcnt_ff - 1;
    end
  end
  assign meas_busy = (mcnt_ff > 0);
  assign comp_active = comp_on;
  assign selftest_done = (tcnt_ff == 1);
  // code only valid with done
  assign selftest_code = selftest_done ? tcode : ~tcode;
endmodule : cch_engine_model

/* File: cch_handler_tb.sv */
// self-checking testbench for the common command handler
// assumes cch_pkg, cch_handler and cch_engine_model compiled first
`timescale 1ns/1ps
module cch_handler_tb;
  // ------------------------------------------------------------
  // signals, model state, tasks
  // ------------------------------------------------------------
  logic pclk, presetn, pready, pslverr, irq, meas_busy, comp_active, selftest_done, last_err;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, comp_on = 1'b0;
  logic [7:0] paddr = 8'h00, tcode = 8'h00, selftest_code;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  cch_pkg::cch_settings_t settings, s_ext;
  cch_pkg::cch_engine_req_t engine_req;
  int error_cnt = 0, comparisons = 0, meas_cnt = 0, clr_cnt = 0, n0 = 0, ext = 0, seed = 76318;
  int pc[3] = '{2, 3, 5};
  localparam logic [31:0] IDW = 32'h5a5a_0102; // arbitrary value
  localparam cch_pkg::cch_settings_t DFLT = '{cch_pkg::PARAM_Z_PHASE, cch_pkg::FREQ_1KHZ,
    cch_pkg::LEVEL_1V, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, cch_pkg::SPEED_NORMAL, 1'b1, 1'b0,
    cch_pkg::CMP_BOTH, 1'b0, 1'b0};
  cch_handler #(.DELAY_CYC(4), .IDENT_WORD(IDW)) cch_handler_inst (.pclk, .presetn, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .meas_busy, .comp_active,
    .selftest_done, .selftest_code, .settings, .engine_req, .irq);
  cch_engine_model cch_engine_model_inst (.pclk, .presetn, .engine_req, .comp_on, .tcode,
    .meas_busy, .comp_active, .selftest_done, .selftest_code);
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    if (engine_req.meas_start === 1'b1) meas_cnt++;
    if (engine_req.panel_clear === 1'b1) clr_cnt++;
  end
  function automatic int exp_sesr(int c, int p, int len, int e, int comp);
    if (p != 0 && (c == 2 || c == 3 || c == 5)) return 1 << cch_pkg::SESR_CME;
    if ((c == 3 && (e == 0 || comp != 0)) || (c == 4 && comp != 0))
      return 1 << cch_pkg::SESR_EXE;
    if ((c == 1 || c == 4) && len > 300) return 1 << cch_pkg::SESR_QYE;
    return 0;
  endfunction : exp_sesr
  task chk(input logic [63:0] got, input logic [63:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task end_sim;
    $display("errors=%0d comparisons=%0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : end_sim
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) begin
      error_cnt++;
      end_sim();
    end
    @(posedge pclk);
  endtask : apb
  task idle;
    int n;
    n = 0;
    do begin
      apb(1'b0, cch_pkg::ADDR_STATUS, 32'h0);
      n++;
    end while (rd[0] !== 1'b0 && n < 200);
    if (n >= 200) begin
      error_cnt++;
      end_sim();
    end
  endtask : idle
  task cmd(input int c, input int p, input int len);
    apb(1'b1, cch_pkg::ADDR_CMD, {len[15:0], 11'h0, p[0], c[3:0]});
    idle();
    apb(1'b0, cch_pkg::ADDR_SESR, 32'h0);
    chk(rd, exp_sesr(c, p, len, ext, comp_on));
    apb(1'b1, cch_pkg::ADDR_SESR, 32'hff);
  endtask : cmd
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    presetn = 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk(settings, DFLT);
    apb(1'b1, cch_pkg::ADDR_INT_MASK, 32'h0);
    cmd(3, 0, 0);
    chk(meas_cnt, 0);
    chk(irq, 1'b0);
    apb(1'b1, cch_pkg::ADDR_INT_MASK, 32'hf);
    chk(irq, 1'b1);
    apb(1'b1, cch_pkg::ADDR_INT_MASK, 32'h0);
    chk(irq, 1'b0);
    apb(1'b1, cch_pkg::ADDR_INT_MASK, 32'hf);
    apb(1'b1, cch_pkg::ADDR_INT_STAT, 32'hf);
    chk(irq, 1'b0);
    apb(1'b1, cch_pkg::ADDR_INT_MASK, 32'h0);
    foreach (pc[i]) cmd(pc[i], 1, 0);
    cmd(1, 0, 300);
    apb(1'b0, cch_pkg::ADDR_RESP, 32'h0);
    chk(rd, IDW);
    cmd(1, 0, 301);
    apb(1'b0, 8'h40, 32'h0);
    chk({rd, last_err}, {32'h0, 1'b1});
    apb(1'b1, cch_pkg::ADDR_CMD, 32'h1);
    apb(1'b1, cch_pkg::ADDR_CMD, 32'h4);
    chk(last_err, 1'b1);
    idle();
    s_ext = DFLT;
    s_ext.trig_ext = 1'b1;
    apb(1'b1, cch_pkg::ADDR_SETTINGS, s_ext[31:0]);
    ext = 1;
    chk(settings.trig_ext, 1'b1);
    cmd(5, 0, 0);
    cmd(3, 0, 0);
    chk(meas_cnt, 1);
    cmd(5, 0, 0);
    chk(meas_busy, 1'b0);
    comp_on <= 1'b1;
    cmd(3, 0, 0);
    cmd(4, 0, 0);
    chk(meas_cnt, 1);
    comp_on <= 1'b0;
    repeat (3) begin
      tcode <= 8'($random(seed));
      cmd(4, 0, 4);
      apb(1'b0, cch_pkg::ADDR_SELFTEST, 32'h0);
      chk(rd, {24'h0, tcode & cch_pkg::TST_USED_MASK});
    end
    n0 = clr_cnt;
    cmd(2, 0, 0);
    chk(settings, DFLT);
    chk(clr_cnt - n0, 1);
    end_sim();
  end
endmodule : cch_handler_tb

bind cch_handler cch_handler_assertions cch_handler_assertions_inst (.pclk, .presetn, .psel,
  .penable, .pwrite, .paddr, .prdata, .pready, .pslverr, .comp_active, .settings, .engine_req);
